// File: ssi_checker.sv
// concurrent checks on the pins of the status and interrupt register group
`timescale 1ns/1ns
`default_nettype none

module ssi_checker (
   input  wire logic core_clk_in,
   input  wire logic resetn_in,
   input  wire logic scl_in,
   input  wire logic processor_watchdog_state_in,
   input  wire logic sda_out,
   input  wire logic sda_oe_out,
   input  wire logic irq_output_pin_n_out,
   input  wire logic irq_output_pin_oe_out,
   input  wire logic config_reset_out,
   input  wire logic device_restart_out
);
   // ==================================================================
   // single domain: clocking given once
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!resetn_in);

   // result pulses are one cycle wide
   sequence s_key_pulse;
      config_reset_out ##1 !config_reset_out;
   endsequence
   sequence s_restart_pulse;
      device_restart_out ##1 !device_restart_out;
   endsequence

   AST_KEY_PULSE: assert property (config_reset_out |-> s_key_pulse)
      else $error("key pulse too wide");
   AST_KEY_ON_LOW_SCL: assert property (config_reset_out |-> !scl_in)
      else $error("key pulse while bus clock high");
   AST_RESTART_AFTER_WD: assert property ($rose(processor_watchdog_state_in) |-> ##[1:6] s_restart_pulse)
      else $error("no restart after watchdog");
   AST_RESTART_CAUSE: assert property (device_restart_out |-> $past(processor_watchdog_state_in, 2))
      else $error("restart pulse without watchdog");
   AST_PUSH_PULL_DRIVES: assert property (irq_output_pin_n_out && $past(resetn_in) |-> irq_output_pin_oe_out)
      else $error("high pin level while not driven");
   // power-on flag hidden by the all-ones mask
   AST_RST_RELEASE: assert property ($rose(resetn_in) |-> (!irq_output_pin_oe_out && !sda_oe_out) [*8])
      else $error("pin active right after reset");
   AST_SDA_ON_LOW_SCL: assert property ($changed(sda_oe_out) |-> !scl_in)
      else $error("data drive moved, clock high");
   AST_SDA_LOW_ONLY: assert property (sda_out == 1'b0)
      else $error("data pin value not low");
endmodule

bind ssi_top ssi_checker chk (
   .core_clk_in, .resetn_in, .scl_in, .processor_watchdog_state_in, .sda_out,
   .sda_oe_out, .irq_output_pin_n_out, .irq_output_pin_oe_out, .config_reset_out,
   .device_restart_out
);
`default_nettype wire

// File: ssi_flags.sv
// latched event flags: set on any status change, cleared by read
`timescale 1ns/1ns
`default_nettype none

module ssi_flags (
   input  wire logic        core_clk_in,
   input  wire logic        resetn_in,
   input  wire logic        clk_en_in,
   input  wire logic [15:0] status_in,
   input  wire logic        read_clear_in,
   output logic      [15:0] flags_out
);

   typedef struct packed {
      logic [15:0] flags;
      logic [15:0] prev;
      logic        primed;
   } ssi_flags_st_t;

   ssi_flags_st_t q;
   ssi_flags_st_t d;
   logic [15:0]   change;

   // ==================================================================
   // per-bit change detect; set wins over a same-cycle read clear
   always_comb begin
      d        = q;
      d.prev   = status_in;
      d.primed = 1'b1;
      // first cycle only loads history, so reset itself is no event
      change   = q.primed ? (status_in ^ q.prev) : 16'h0000;   // RULE15
      d.flags  = (read_clear_in ? 16'h0000 : q.flags) | change; // RULE16
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         q       <= '0;
         q.flags <= ssi_pkg::FLAGS_RST; // RULE14
      end else if (clk_en_in) begin
         q <= d;
      end
   end

   assign flags_out = q.flags;

endmodule
`default_nettype wire

// File: ssi_host_model.sv
// host model that reaches the register group over the serial control bus
`timescale 1ns/1ns
`default_nettype none

module ssi_host_model (
   input  wire logic       core_clk_in,
   input  wire logic       sda_line_in,
   input  wire logic [6:0] dev_in,
   output var logic        scl_out,
   output var logic        sda_out
);
   // ==================================================================
   // a one releases the line to its pull-up
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end

   task automatic wait_n(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask

   // data moves well after the clock falls
   task automatic bit_io(input logic b, output logic r);
      wait_n(4);
      sda_out <= b;
      wait_n(6);
      scl_out <= 1'b1;
      wait_n(10);
      r = sda_line_in;
      scl_out <= 1'b0;
   endtask

   // start, repeated start or stop, from either clock level
   task automatic cond_c(input logic is_start);
      wait_n(4);
      sda_out <= is_start;
      wait_n(6);
      scl_out <= 1'b1;
      wait_n(10);
      sda_out <= ~is_start;
      wait_n(10);
      if (is_start) begin
         scl_out <= 1'b0;
      end
   endtask

   task automatic put_byte(input logic [7:0] d, inout logic ok);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ok = ok & ~r;
   endtask

   task automatic get_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(last, r);
   endtask

   // ok low on any missing ack
   task automatic write_reg(input logic [7:0] a, input logic [15:0] v, output logic ok);
      ok = 1'b1;
      cond_c(1'b1);
      put_byte({dev_in, 1'b0}, ok);
      put_byte(a, ok);
      put_byte(v[15:8], ok);
      put_byte(v[7:0], ok);
      cond_c(1'b0);
   endtask

   task automatic read_reg(input logic [7:0] a, output logic [15:0] v);
      logic ok;
      ok = 1'b1;
      cond_c(1'b1);
      put_byte({dev_in, 1'b0}, ok);
      put_byte(a, ok);
      cond_c(1'b1);
      put_byte({dev_in, 1'b1}, ok);
      get_byte(1'b0, v[15:8]);
      get_byte(1'b1, v[7:0]);
      cond_c(1'b0);
   endtask
endmodule
`default_nettype wire

// File: ssi_pkg.sv
// constants shared by the status and interrupt register group
package ssi_pkg;

   // ==================================================================
   // register map (word addresses on the serial control bus)
   localparam logic [7:0]  ADDR_ID      = 8'h00;
   localparam logic [7:0]  ADDR_STATUS  = 8'h01;
   localparam logic [7:0]  ADDR_FLAGS   = 8'h02;
   localparam logic [7:0]  ADDR_MASK    = 8'h03;
   localparam logic [7:0]  ADDR_CTRL    = 8'h04;

   // ==================================================================
   // identity and reset key
   localparam logic [15:0] PART_CODE    = 16'hA5C3;   // value is arbitrary
   localparam logic [15:0] RESET_KEY    = 16'h55AA;

   // ==================================================================
   // reset values and field layout
   localparam logic [15:0] MASK_RST     = 16'hFFFF;
   localparam logic [15:0] MASK_RSVD    = 16'h8000;   // reserved bit reads one
   localparam logic [15:0] CTRL_RST     = 16'h6007;
   localparam logic [15:0] CTRL_WMASK   = 16'h7FFB;   // bits 15 and 2 reserved
   localparam logic [15:0] CTRL_RSVD    = 16'h0004;
   localparam logic [15:0] FLAGS_RST    = 16'h4000;   // power-on event flag
   localparam int          CFG_SRC_BIT  = 8;          // 0: flags, 1: live status
   localparam int          CFG_PP_BIT   = 9;          // 0: open drain, 1: push-pull
   localparam int          WD_BIT       = 6;
   localparam int          UV_BIT       = 14;

   // ==================================================================
   // serial control bus
   localparam logic [4:0]  DEV_BASE     = 5'b01101;   // upper address bits
   localparam logic [3:0]  BITS_BYTE    = 4'h8;

   // synchronised input vector layout
   localparam int          SYN_W        = 20;
   localparam int          SYN_SCL      = 19;
   localparam int          SYN_SDA      = 18;
   localparam int          SYN_AD_HI    = 17;
   localparam int          SYN_AD_LO    = 16;
   localparam int          SYN_BELOW    = 15;
   localparam int          SYN_ABOVE    = 14;

   typedef enum logic [2:0] {
      SSI_IDLE = 3'b000,
      SSI_ADDR = 3'b001,
      SSI_REG  = 3'b010,
      SSI_WRD  = 3'b011,
      SSI_ACK  = 3'b100,
      SSI_TX   = 3'b101,
      SSI_MACK = 3'b110
   } ssi_bus_st_t;

endpackage

// File: ssi_sync.sv
// two-stage synchroniser bank for pins and monitor levels
`timescale 1ns/1ns
`default_nettype none

module ssi_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk_in,
   input  wire logic         resetn_in,
   input  wire logic         clk_en_in,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } ssi_sync_st_t;

   ssi_sync_st_t q;
   ssi_sync_st_t d;

   // ==================================================================
   // first stage feeds only the second stage
   always_comb begin
      d      = q;
      d.meta = async_in;
      d.stab = q.meta;
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         q <= '0;
      end else if (clk_en_in) begin
         q <= d;
      end
   end

   assign sync_out = q.stab;

endmodule
`default_nettype wire

// File: ssi_top.sv
// status, event flag and mask registers behind the serial control bus
// Functional notes
// RULE1: identity register at address zero reads the fixed sixteen-bit part code
// RULE2: writing the key to address zero restores all configuration registers
// RULE3: bit 14 sets below lower supply threshold, clears above upper one
// RULE4: bit 13 shows boost state, zero pass-through, one boosting
// RULE5: bit 12 follows the processor acknowledge-request flag
// RULE6: bit 11 boost over-current, bit 10 boost over-voltage
// RULE7: bit 9 reads one once boost start-up has finished
// RULE8: bit 8 output stage switching, bit 7 amplifier clipping
// RULE9: bit 6 shows watchdog firing, and the device then restarts
// RULE10: bit 5 reference clock missing, bit 4 all clocks stable
// RULE11: bit 3 amplifier over-current, bit 2 clipping pre-warning
// RULE12: bit 1 reads one while die is over temperature
// RULE13: bit 0 reads one while the loop is locked
// RULE14: flag 14 set at power-on and on supply-low status change
// RULE15: each flag latches when its matching status bit changes
// RULE16: reading the flag register returns the flags then clears them
// RULE17: a mask bit at one suppresses its flag; all default one
// RULE18: two-bit field picks pin source and open-drain or push-pull drive
// RULE19: pin asserts while any unmasked flag is set, releases after clearing
`timescale 1ns/1ns
`default_nettype none

module ssi_top (
   input  wire logic core_clk_in,
   input  wire logic resetn_in,
   input  wire logic clk_en_in,
   // serial control bus, open drain
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe_out,
   input  wire logic dev_addr_sel_hi_in,
   input  wire logic dev_addr_sel_lo_in,
   // monitor levels
   input  wire logic supply_below_low_in,
   input  wire logic supply_above_high_in,
   input  wire logic adaptive_boost_state_in,
   input  wire logic processor_ack_state_in,
   input  wire logic boost_overcurrent_state_in,
   input  wire logic boost_overvoltage_state_in,
   input  wire logic boost_startup_done_in,
   input  wire logic amp_switching_state_in,
   input  wire logic output_clipping_state_in,
   input  wire logic processor_watchdog_state_in,
   input  wire logic reference_clock_missing_in,
   input  wire logic clocks_stable_state_in,
   input  wire logic amp_overcurrent_state_in,
   input  wire logic clip_warning_state_in,
   input  wire logic overheat_state_in,
   input  wire logic loop_locked_state_in,
   // results
   output logic      irq_output_pin_n_out,
   output logic      irq_output_pin_oe_out,
   output logic      config_reset_out,
   output logic      device_restart_out
);

   typedef struct packed {
      ssi_pkg::ssi_bus_st_t st;
      logic [3:0]           cnt;
      logic [7:0]           sh;
      logic [15:0]          tx;
      logic                 lo;
      logic                 rw;
      logic [1:0]           ph;
      logic [7:0]           reg_addr;
      logic [7:0]           hi_b;
      logic                 sda_o;
      logic                 sda_oe;
      logic                 scl_p;
      logic                 sda_p;
      logic                 mack;
      logic [15:0]          mask;
      logic [15:0]          ctrl;
      logic                 uv;
      logic                 irq_n;
      logic                 irq_oe;
      logic                 cfg_rst;
      logic                 restart;
      logic                 wd_p;
   } ssi_top_st_t;

   ssi_top_st_t                  q;
   ssi_top_st_t                  d;
   logic [ssi_pkg::SYN_W-1:0]    sy;
   logic [15:0]                  status;
   logic [15:0]                  flags;
   logic                         rd_clr;

   // ==================================================================
   // synchronise every pin and monitor level
   ssi_sync #(
      .W (ssi_pkg::SYN_W)
   ) u_sync (
      .core_clk_in (core_clk_in),
      .resetn_in   (resetn_in),
      .clk_en_in   (clk_en_in),
      .async_in    ({scl_in, sda_in, dev_addr_sel_hi_in, dev_addr_sel_lo_in,
                     supply_below_low_in, supply_above_high_in,
                     adaptive_boost_state_in, processor_ack_state_in,
                     boost_overcurrent_state_in, boost_overvoltage_state_in,
                     boost_startup_done_in, amp_switching_state_in,
                     output_clipping_state_in, processor_watchdog_state_in,
                     reference_clock_missing_in, clocks_stable_state_in,
                     amp_overcurrent_state_in, clip_warning_state_in,
                     overheat_state_in, loop_locked_state_in}),
      .sync_out    (sy)
   );

   // ==================================================================
   // live condition word; bit 15 reserved, reads zero
   assign status = {1'b0, q.uv, sy[13:0]}; // RULE4 RULE5 RULE6 RULE7 RULE8 RULE10 RULE11 RULE12 RULE13

   ssi_flags u_flags (
      .core_clk_in   (core_clk_in),
      .resetn_in     (resetn_in),
      .clk_en_in     (clk_en_in),
      .status_in     (status),
      .read_clear_in (rd_clr),
      .flags_out     (flags)
   );

   // ==================================================================
   // register read decode, used for first and follow-on words
   function automatic logic [15:0] rd_word(input logic [7:0]  a,
                                           input logic [15:0] st_w,
                                           input logic [15:0] fl_w,
                                           input logic [15:0] mk_w,
                                           input logic [15:0] ct_w);
      logic [15:0] r;
      r = 16'h0000;
      if (a == ssi_pkg::ADDR_ID) begin
         r = ssi_pkg::PART_CODE; // RULE1
      end else if (a == ssi_pkg::ADDR_STATUS) begin
         r = st_w;
      end else if (a == ssi_pkg::ADDR_FLAGS) begin
         r = fl_w;
      end else if (a == ssi_pkg::ADDR_MASK) begin
         r = mk_w;
      end else if (a == ssi_pkg::ADDR_CTRL) begin
         r = ct_w;
      end
      return r;
   endfunction

   // ==================================================================
   // bus slave, register writes, hysteresis and pin drive
   always_comb begin
      logic        scl;
      logic        sda;
      logic        scl_rise;
      logic        scl_fall;
      logic        start;
      logic        stop;
      logic        fetch;
      logic [7:0]  f_addr;
      logic [15:0] f_word;
      logic        wr;
      logic [15:0] wdata;
      logic [15:0] src;
      logic        pend;
      scl      = sy[ssi_pkg::SYN_SCL];
      sda      = sy[ssi_pkg::SYN_SDA];
      scl_rise = scl & ~q.scl_p;
      scl_fall = ~scl & q.scl_p;
      start    = scl & q.scl_p & q.sda_p & ~sda;
      stop     = scl & q.scl_p & ~q.sda_p & sda;
      fetch    = 1'b0;
      f_addr   = q.reg_addr;
      wr       = 1'b0;
      wdata    = {q.hi_b, q.sh};
      d        = q;
      d.scl_p  = scl;
      d.sda_p  = sda;
      d.cfg_rst = 1'b0;
      d.restart = 1'b0;

      // start and stop override any bit in flight
      if (start) begin
         d.st     = ssi_pkg::SSI_ADDR;
         d.cnt    = 4'h0;
         d.lo     = 1'b0;
         d.sda_oe = 1'b0;
      end else if (stop) begin
         d.st     = ssi_pkg::SSI_IDLE;
         d.sda_oe = 1'b0;
      end else begin
         case (q.st)
            ssi_pkg::SSI_ADDR, ssi_pkg::SSI_REG, ssi_pkg::SSI_WRD: begin
               if (scl_rise) begin
                  d.sh  = {q.sh[6:0], sda};
                  d.cnt = q.cnt + 4'h1;
               end else if (scl_fall && q.cnt == ssi_pkg::BITS_BYTE) begin
                  d.cnt    = 4'h0;
                  d.st     = ssi_pkg::SSI_ACK;
                  d.sda_oe = 1'b1;
                  if (q.st == ssi_pkg::SSI_ADDR) begin
                     d.ph = 2'h0;
                     d.rw = q.sh[0];
                     // silent unless our own address is called
                     if (q.sh[7:1] != {ssi_pkg::DEV_BASE, sy[ssi_pkg::SYN_AD_HI],
                                       sy[ssi_pkg::SYN_AD_LO]}) begin
                        d.st     = ssi_pkg::SSI_IDLE;
                        d.sda_oe = 1'b0;
                     end
                  end else if (q.st == ssi_pkg::SSI_REG) begin
                     d.ph       = 2'h1;
                     d.reg_addr = q.sh;
                     d.lo       = 1'b0;
                  end else begin
                     d.ph = 2'h2;
                     if (!q.lo) begin
                        d.hi_b = q.sh;
                        d.lo   = 1'b1;
                     end else begin
                        wr         = 1'b1;
                        d.lo       = 1'b0;
                        d.reg_addr = q.reg_addr + 8'h01;
                     end
                  end
               end
            end
            ssi_pkg::SSI_ACK: begin
               if (scl_fall) begin
                  d.sda_oe = 1'b0;
                  d.cnt    = 4'h0;
                  if (q.ph == 2'h0 && q.rw) begin
                     fetch = 1'b1;
                     d.st  = ssi_pkg::SSI_TX;
                  end else if (q.ph == 2'h0) begin
                     d.st = ssi_pkg::SSI_REG;
                  end else begin
                     d.st = ssi_pkg::SSI_WRD;
                  end
               end
            end
            ssi_pkg::SSI_TX: begin
               if (scl_fall) begin
                  d.tx  = {q.tx[14:0], 1'b0};
                  d.cnt = q.cnt + 4'h1;
                  if (q.cnt == ssi_pkg::BITS_BYTE - 4'h1) begin
                     d.sda_oe = 1'b0;
                     d.st     = ssi_pkg::SSI_MACK;
                  end else begin
                     d.sda_oe = ~q.tx[14];
                  end
               end
            end
            ssi_pkg::SSI_MACK: begin
               if (scl_rise) begin
                  d.mack = ~sda;
               end else if (scl_fall) begin
                  d.cnt = 4'h0;
                  if (!q.mack) begin
                     d.st = ssi_pkg::SSI_IDLE;   // no ack: wait for stop
                  end else if (!q.lo) begin
                     d.lo     = 1'b1;
                     d.st     = ssi_pkg::SSI_TX;
                     d.sda_oe = ~q.tx[15];
                  end else begin
                     f_addr     = q.reg_addr + 8'h01;
                     d.reg_addr = f_addr;
                     fetch      = 1'b1;
                     d.st       = ssi_pkg::SSI_TX;
                  end
               end
            end
            default: begin
               d.sda_oe = 1'b0;
            end
         endcase
      end

      // word is captured in the same cycle the flags are cleared,
      // so an event landing then survives into the next read
      f_word = rd_word(f_addr, status, flags, q.mask, q.ctrl);
      rd_clr = fetch && (f_addr == ssi_pkg::ADDR_FLAGS); // RULE16
      if (fetch) begin
         d.tx     = f_word;
         d.lo     = 1'b0;
         d.sda_oe = ~f_word[15];
      end

      // register writes; identity key restores configuration
      if (wr) begin
         if (q.reg_addr == ssi_pkg::ADDR_ID) begin
            if (wdata == ssi_pkg::RESET_KEY) begin
               d.mask    = ssi_pkg::MASK_RST; // RULE2
               d.ctrl    = ssi_pkg::CTRL_RST;
               d.cfg_rst = 1'b1;
            end
         end else if (q.reg_addr == ssi_pkg::ADDR_MASK) begin
            d.mask = wdata | ssi_pkg::MASK_RSVD;
         end else if (q.reg_addr == ssi_pkg::ADDR_CTRL) begin
            d.ctrl = (wdata & ssi_pkg::CTRL_WMASK) | ssi_pkg::CTRL_RSVD;
         end
      end

      // supply-low hysteresis between the two comparator levels
      if (sy[ssi_pkg::SYN_BELOW]) begin
         d.uv = 1'b1; // RULE3
      end else if (sy[ssi_pkg::SYN_ABOVE]) begin
         d.uv = 1'b0; // RULE3
      end

      // watchdog rising edge asks the device to restart
      d.wd_p    = status[ssi_pkg::WD_BIT];
      d.restart = status[ssi_pkg::WD_BIT] & ~q.wd_p; // RULE9

      // interrupt pin, active low
      src  = q.ctrl[ssi_pkg::CFG_SRC_BIT] ? status : flags; // RULE18
      pend = |(src & ~q.mask); // RULE17 RULE19
      if (q.ctrl[ssi_pkg::CFG_PP_BIT]) begin
         d.irq_oe = 1'b1; // RULE18
         d.irq_n  = ~pend;
      end else begin
         d.irq_oe = pend; // open drain only ever pulls low
         d.irq_n  = 1'b0;
      end
   end

   // ==================================================================
   // state register, frozen while the clock enable is low
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         q       <= '0;
         q.mask  <= ssi_pkg::MASK_RST; // RULE17
         q.ctrl  <= ssi_pkg::CTRL_RST;
         q.irq_n <= 1'b1;
      end else if (clk_en_in) begin
         q <= d;
      end
   end

   // ==================================================================
   // outputs straight from flip-flops
   assign sda_out               = q.sda_o;
   assign sda_oe_out            = q.sda_oe;
   assign irq_output_pin_n_out  = q.irq_n;
   assign irq_output_pin_oe_out = q.irq_oe;
   assign config_reset_out      = q.cfg_rst;
   assign device_restart_out    = q.restart;

endmodule
`default_nettype wire

// File: ssi_top_bench.sv
// self-checking bench for the status and interrupt register group
`timescale 1ns/1ns
`default_nettype none

module ssi_top_bench;
   typedef struct packed {
      logic [15:0] mon;
      logic [7:0]  addr;
      logic [15:0] exp;
   } ssi_row_t;

   logic        core_clk_in = 1'b0;
   logic        resetn_in   = 1'b0;
   logic [15:0] mon         = 16'h0000;   // above, below, status 13..0
   logic [6:0]  host_dev    = 7'h36;
   logic        scl;
   logic        sda_m;
   logic        sda_o;
   logic        sda_oe;
   logic        sda_line;
   logic        irq_n;
   logic        irq_oe;
   logic        cfg_rst;
   logic        restart;
   logic [15:0] rd;
   logic        ok;
   int          failures    = 0;
   int          compares    = 0;
   int          cycles      = 0;
   int          key_pulses  = 0;
   int          restarts    = 0;
   ssi_row_t    rows [13];

   // open-drain data line with pull-up
   assign sda_line = sda_m & ~sda_oe;

   always #25 core_clk_in = ~core_clk_in;

   ssi_top uut (
      .core_clk_in, .resetn_in, .clk_en_in(1'b1),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o), .sda_oe_out(sda_oe),
      .dev_addr_sel_hi_in(1'b1), .dev_addr_sel_lo_in(1'b0),
      .supply_below_low_in(mon[14]), .supply_above_high_in(mon[15]),
      .adaptive_boost_state_in(mon[13]), .processor_ack_state_in(mon[12]),
      .boost_overcurrent_state_in(mon[11]), .boost_overvoltage_state_in(mon[10]),
      .boost_startup_done_in(mon[9]), .amp_switching_state_in(mon[8]),
      .output_clipping_state_in(mon[7]), .processor_watchdog_state_in(mon[6]),
      .reference_clock_missing_in(mon[5]), .clocks_stable_state_in(mon[4]),
      .amp_overcurrent_state_in(mon[3]), .clip_warning_state_in(mon[2]),
      .overheat_state_in(mon[1]), .loop_locked_state_in(mon[0]),
      .irq_output_pin_n_out(irq_n), .irq_output_pin_oe_out(irq_oe),
      .config_reset_out(cfg_rst), .device_restart_out(restart)
   );

   ssi_host_model host (
      .core_clk_in, .sda_line_in(sda_line), .dev_in(host_dev),
      .scl_out(scl), .sda_out(sda_m)
   );

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // limit about two and a half times the run; pulse counters
   always @(posedge core_clk_in) begin
      cycles <= cycles + 1;
      key_pulses <= key_pulses + int'(cfg_rst === 1'b1);
      restarts <= restarts + int'(restart === 1'b1);
      if (cycles == 60000) begin
         failures++;
         finish_test();
      end
   end

   // ==================================================================
   // row table, then hand-written cases
   initial begin
      rows = '{
         '{16'h0000, ssi_pkg::ADDR_ID, ssi_pkg::PART_CODE},
         '{16'h0000, ssi_pkg::ADDR_FLAGS, ssi_pkg::FLAGS_RST},
         '{16'h0000, ssi_pkg::ADDR_FLAGS, 16'h0000},
         '{16'h0000, ssi_pkg::ADDR_MASK, ssi_pkg::MASK_RST},
         '{16'h0000, ssi_pkg::ADDR_CTRL, ssi_pkg::CTRL_RST},
         '{16'h0000, 8'h07, 16'h0000},
         '{16'h2AAA, ssi_pkg::ADDR_STATUS, 16'h2AAA},
         '{16'h1555, ssi_pkg::ADDR_STATUS, 16'h1555},
         '{16'h4000, ssi_pkg::ADDR_STATUS, 16'h4000},
         '{16'h0000, ssi_pkg::ADDR_STATUS, 16'h4000},
         '{16'h8000, ssi_pkg::ADDR_STATUS, 16'h0000},
         '{16'h0000, ssi_pkg::ADDR_FLAGS, 16'h7FFF},
         '{16'h0000, ssi_pkg::ADDR_FLAGS, 16'h0000}
      };
      repeat (3) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      repeat (5) @(posedge core_clk_in);
      foreach (rows[i]) begin
         mon <= rows[i].mon;
         repeat (8) @(posedge core_clk_in);
         host.read_reg(rows[i].addr, rd);
         check("row read", rd, rows[i].exp);
      end
      // unmasked source pulls the pin until read
      host.write_reg(ssi_pkg::ADDR_MASK, 16'h7FF7, ok);
      host.read_reg(ssi_pkg::ADDR_MASK, rd);
      check("mask", rd, 16'hFFF7);
      check("pin idle", {14'h0, irq_oe, irq_n}, 16'h0000);
      mon <= 16'h0008;
      repeat (8) @(posedge core_clk_in);
      check("pin set", {14'h0, irq_oe, irq_n}, 16'h0002);
      host.read_reg(ssi_pkg::ADDR_FLAGS, rd);
      check("flag", rd, 16'h0008);
      repeat (3) @(posedge core_clk_in);
      check("pin free", {14'h0, irq_oe, irq_n}, 16'h0000);
      // push-pull, then live status as the pin source
      host.write_reg(ssi_pkg::ADDR_CTRL, 16'h6207, ok);
      check("push-pull idle", {14'h0, irq_oe, irq_n}, 16'h0003);
      host.write_reg(ssi_pkg::ADDR_CTRL, 16'h6307, ok);
      check("status source", {14'h0, irq_oe, irq_n}, 16'h0002);
      // a wrong key is ignored, the right one restores the defaults
      host.write_reg(ssi_pkg::ADDR_ID, 16'h1234, ok);
      host.read_reg(ssi_pkg::ADDR_CTRL, rd);
      check("ctrl kept", rd, 16'h6307);
      host.write_reg(ssi_pkg::ADDR_ID, ssi_pkg::RESET_KEY, ok);
      check("key pulses", {15'h0, ok} | 16'(key_pulses << 4), 16'h0011);
      host.read_reg(ssi_pkg::ADDR_CTRL, rd);
      check("ctrl back", rd, ssi_pkg::CTRL_RST);
      check("restarts", 16'(restarts), 16'h0001);
      // foreign address leaves the mask alone
      host_dev <= 7'h34;
      host.write_reg(ssi_pkg::ADDR_MASK, 16'h0000, ok);
      check("foreign ack", {15'h0, ok}, 16'h0000);
      host_dev <= 7'h36;
      host.read_reg(ssi_pkg::ADDR_MASK, rd);
      check("mask back", rd, ssi_pkg::MASK_RST);
      // mid-run reset restores power-on flag
      resetn_in <= 1'b0;
      mon <= 16'h0000;
      repeat (3) @(posedge core_clk_in);
      check("pin in reset", {14'h0, irq_oe, irq_n}, 16'h0001);
      resetn_in <= 1'b1;
      repeat (5) @(posedge core_clk_in);
      host.read_reg(ssi_pkg::ADDR_FLAGS, rd);
      check("power-on flag", rd, ssi_pkg::FLAGS_RST);
      finish_test();
   end
endmodule
`default_nettype wire
